/* File: hdl/gpio_regs.sv */
// Pin configuration, input readback and output data registers
`include "gpio_regs_defines.svh"
module gpio_regs (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic [2:0] PIN_I,
  output logic      [2:0] PIN_O,
  output logic      [2:0] PIN_OE,
  input  wire logic [1:0] PIN_OUT_ON,
  input  wire logic [1:0] PIN_IN_ON
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  gpio_regs_pkg::reg_req_t  req;
  gpio_regs_pkg::pin2_cfg_t cfg_q;
  logic [2:0] out_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] in_on;
  logic [2:0] out_on;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  assign in_on  = {cfg_q.in_buf_on, PIN_IN_ON};
  assign out_on = {cfg_q.pin2_output_drive_on, PIN_OUT_ON};

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cfg_q <= gpio_regs_pkg::pin2_cfg_t'(`RST_PIN2_CFG);
    end else if (req.wr && req.addr == `OFS_PIN2_CFG) begin
      cfg_q <= gpio_regs_pkg::pin2_cfg_t'(req.wdata);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      out_q <= 3'(`RST_PIN_OUT);
    end else if (req.wr && req.addr == `OFS_PIN_OUT) begin
      out_q <= req.wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser; buffer off reads as low
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= PIN_I;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive; pin2 falls back to floating for non-register sources
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PIN_O  <= 3'h0;
      PIN_OE <= 3'h0;
    end else begin
      PIN_O[1:0]  <= out_q[1:0];
      PIN_OE[1:0] <= out_on[1:0];
      // Internal clock/status sources are outside this block, so drive nothing
      PIN_O[2]  <= (cfg_q.mode == `MODE_GP_REG) ? out_q[2] : 1'b0;
      PIN_OE[2] <= out_on[2] && (cfg_q.mode == `MODE_GP_REG);
    end
  end

  // ----------------------------------------------------------------
  // Read path, no side effects
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `OFS_PIN2_CFG: REG_RDATA <= cfg_q;
        `OFS_PIN_IN:   REG_RDATA <= {5'h00, sync2_q & in_on};
        `OFS_PIN_OUT:  REG_RDATA <= {5'h00, out_q};
        default:       REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_cfg_reset: assert property (@(posedge REF_CLK) $past(SYS_RST) |->
    !cfg_q.in_buf_on && !cfg_q.pin2_output_drive_on)
    else $error("pin2 config bits not reset to zero");
  a_pin2_float: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !cfg_q.pin2_output_drive_on |=> !PIN_OE[2])
    else $error("pin2 driven with driver disabled");
  a_in_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN_IN |=> REG_RDATA == {5'h00, $past(sync2_q & in_on)})
    else $error("input readback wrong");
  a_in_reserved: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $past(req.rd) && $past(req.addr) == `OFS_PIN_IN |-> REG_RDATA[7:3] == 5'h00)
    else $error("reserved input bits nonzero");
  a_out_pass: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.wr && req.addr == `OFS_PIN_OUT ##1 out_on[0] |=> PIN_O[0] == $past(req.wdata[0], 2))
    else $error("output data not passed to pin");
  a_pin2_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cfg_q.mode == `MODE_GP_REG |=> PIN_O[2] == $past(out_q[2]))
    else $error("pin2 level mismatch");
  a_mode_gate: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cfg_q.mode != `MODE_GP_REG |=> !PIN_OE[2])
    else $error("pin2 driven from register in other mode");
  a_unmapped_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr != `OFS_PIN2_CFG && req.addr != `OFS_PIN_IN
    && req.addr != `OFS_PIN_OUT |=> REG_RDATA == 8'h00)
    else $error("unmapped read nonzero");
  a_read_clean: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && !req.wr |=> $stable(out_q) && $stable(cfg_q))
    else $error("read changed state");

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  a_drive_reset: assert property (@(posedge REF_CLK)
    $past(SYS_RST)
    |-> PIN_OE == 3'h0 && PIN_O == 3'h0)
    else $error("pins driven right after reset");
  a_out_reset: assert property (@(posedge REF_CLK)
    $past(SYS_RST)
    |-> out_q == 3'h0)
    else $error("output data not reset");
  a_rdata_reset: assert property (@(posedge REF_CLK)
    $past(SYS_RST)
    |-> REG_RDATA == 8'h00)
    else $error("read data not reset");
  a_mode_reset: assert property (@(posedge REF_CLK)
    $past(SYS_RST)
    |-> cfg_q.mode == `MODE_GP_REG)
    else $error("pin2 source not reset to register");

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  a_cfg_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.wr && req.addr == `OFS_PIN2_CFG
    |=> cfg_q == $past(req.wdata))
    else $error("pin2 config write lost");
  a_cfg_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(req.wr && req.addr == `OFS_PIN2_CFG)
    |=> $stable(cfg_q))
    else $error("pin2 config changed without write");
  a_out_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.wr && req.addr == `OFS_PIN_OUT
    |=> out_q == $past(req.wdata[2:0]))
    else $error("output data write lost");
  a_out_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(req.wr && req.addr == `OFS_PIN_OUT)
    |=> $stable(out_q))
    else $error("output data changed without write");

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  a_pin0_enable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1
    |=> PIN_OE[0] == $past(out_on[0]))
    else $error("pin0 enable not followed");
  a_pin1_enable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1
    |=> PIN_OE[1] == $past(out_on[1]))
    else $error("pin1 enable not followed");
  a_pin0_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1
    |=> PIN_O[0] == $past(out_q[0]))
    else $error("pin0 level not followed");
  a_pin1_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1
    |=> PIN_O[1] == $past(out_q[1]))
    else $error("pin1 level not followed");
  a_pin2_enable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    out_on[2] && cfg_q.mode == `MODE_GP_REG
    |=> PIN_OE[2])
    else $error("pin2 not driven with driver on");
  a_pin2_quiet: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cfg_q.mode != `MODE_GP_REG
    |=> !PIN_O[2])
    else $error("pin2 level shown in other mode");

  // ----------------------------------------------------------------
  // Read path, synchroniser and pin2 enable source
  // ----------------------------------------------------------------
  a_cfg_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN2_CFG
    |=> REG_RDATA == $past(cfg_q))
    else $error("pin2 config readback wrong");
  a_out_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN_OUT
    |=> REG_RDATA == {5'h00, $past(out_q)})
    else $error("output data readback wrong");
  a_in_bit0: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN_IN
    |=> REG_RDATA[0] == $past(sync2_q[0] && in_on[0]))
    else $error("pin0 input bit misplaced");
  a_in_bit1: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN_IN
    |=> REG_RDATA[1] == $past(sync2_q[1] && in_on[1]))
    else $error("pin1 input bit misplaced");
  a_in_buf_gate: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req.rd && req.addr == `OFS_PIN_IN && !cfg_q.in_buf_on
    |=> !REG_RDATA[2])
    else $error("pin2 input seen with buffer off");
  a_rdata_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !req.rd
    |=> $stable(REG_RDATA))
    else $error("read data changed without read");
  a_sync_stage: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1
    |=> sync2_q == $past(sync1_q))
    else $error("synchroniser stage skipped");
  a_pin2_tied_reg: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cfg_q.mode == `MODE_GP_REG
    |=> PIN_OE[2] == $past(cfg_q.pin2_output_drive_on))
    else $error("pin2 enable not from config bit");
  c_pin2_drive: cover property (@(posedge REF_CLK) PIN_OE[2] && PIN_O[2]);
  c_in_read: cover property (@(posedge REF_CLK) req.rd && req.addr == `OFS_PIN_IN && in_on[2]);
  c_mode_other: cover property (@(posedge REF_CLK) cfg_q.mode != `MODE_GP_REG);
  c_pin01_drive: cover property (@(posedge REF_CLK) PIN_OE[1:0] == 2'b11);
  c_unmapped_read: cover property (@(posedge REF_CLK) req.rd && req.addr > `OFS_PIN_OUT);
endmodule // gpio_regs

/* File: hdl/gpio_regs_defines.svh */
// Offsets, field positions, reset values for the general pin register set
`ifndef GPIO_REGS_DEFINES_SVH
`define GPIO_REGS_DEFINES_SVH
`define OFS_PIN2_CFG     8'h04
`define OFS_PIN_IN       8'h05
`define OFS_PIN_OUT      8'h06
`define BIT_OUT_DRIVE    0
`define BIT_IN_BUF       1
`define LSB_MODE         4
`define LSB_PULL         2
`define RST_PIN2_CFG     8'h04
`define RST_PIN_OUT      8'h00
`define MODE_GP_REG      4'h0
`define NUM_PINS         3
`endif

/* File: hdl/gpio_regs_pkg.sv */
// Types for the general pin register set
package gpio_regs_pkg;
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] pull;
    logic       in_buf_on;
    logic       pin2_output_drive_on;
  } pin2_cfg_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

/* File: bench/pin_board.sv */
// Board-side model of the three general pins
module pin_board (
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext,
  output logic      [2:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin shows the device level, a floating one the board level
  always_comb
    for (int i = 0; i < 3; i++) pin_i[i] = pin_oe[i] ? pin_o[i] : ext[i];
endmodule // pin_board

/* File: bench/testbench.sv */
// Self-checking bench for the general pin registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] pin_i, pin_o, pin_oe, ext = 3'h0;
  logic [1:0] out_on = 2'h0, in_on = 2'h0;
  int         err_count = 0, n_tests = 0, cyc = 0;
  // Rows: offset, written value, value read back
  logic [7:0] rows [5][3] = '{'{8'h06, 8'hff, 8'h07}, '{8'h04, 8'h03, 8'h03},
    '{8'h04, 8'hf1, 8'hf1}, '{8'h10, 8'h5a, 8'h00}, '{8'h05, 8'hff, 8'h00}};
  gpio_regs i_dut (.REF_CLK(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_OUT_ON(out_on), .PIN_IN_ON(in_on));
  pin_board i_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  initial forever #20 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 0;
  endtask
  // Read data is sampled a full cycle late, it holds until the next read
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    chk({5'h0, pin_oe}, 8'h00);
    rd_reg(8'h04, 8'h04);
    rd_reg(8'h06, 8'h00);
    for (int r = 0; r < 5; r++) begin
      wr_reg(rows[r][0], rows[r][1]);
      rd_reg(rows[r][0], rows[r][2]);
    end
    wr_reg(8'h04, 8'h01);
    wr_reg(8'h06, 8'h04);
    repeat (2) @(negedge clk);
    chk({6'h0, pin_oe[2], pin_o[2]}, 8'h03);
    wr_reg(8'h04, 8'h11);
    repeat (2) @(negedge clk);
    chk({7'h0, pin_oe[2]}, 8'h00);
    wr_reg(8'h04, 8'h02);
    ext = 3'h5;
    in_on = 2'h1;
    repeat (3) @(negedge clk);
    rd_reg(8'h05, 8'h05);
    rd_reg(8'h04, 8'h02);
    in_on = 2'h0;
    wr_reg(8'h04, 8'h00);
    repeat (3) @(negedge clk);
    rd_reg(8'h05, 8'h00);
    out_on = 2'h3;
    wr_reg(8'h06, 8'h02);
    repeat (2) @(negedge clk);
    chk({2'h0, pin_oe, pin_o}, 8'h1a);
    out_on = 2'h0;
    wr_reg(8'h04, 8'h03);
    @(negedge clk) rst = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    chk({5'h0, pin_oe}, 8'h00);
    rd_reg(8'h04, 8'h04);
    rd_reg(8'h06, 8'h00);
    stop_test();
  end
endmodule // testbench
